/* File: design/ssl_regs.vh */
// Constants for the serial shift latch driver.
// What this block does
// - Eight shift stages feed an eight-bit storage register, one output per bit.
// - Each shift clock rising edge moves the stages up one and loads serial_in.
// - Each latch clock rising edge copies all shift stages into storage at once.
// - cascade_out shows the last shift stage and changes only on shift edges and clears.
// - A low clear_n clears shift and storage registers at once, with no shift or latch clock.
// - With both clocks tied, storage holds the shift state of one pulse before.
// - With output enable low, each drain is driven from its storage bit.
// - With output enable high, all eight drains are off and float.
// - The output enable never changes the shift or storage contents.
// - Each drain is open-drain: a one sinks current, a zero leaves it off.
`ifndef SSL_REGS_VH
`define SSL_REGS_VH
`define SSL_WIDTH       8
`define SSL_BUF_DEPTH   2
`define SSL_SYNC_STAGES 2
`endif

/* File: design/ssl_sync.v */
// Two flip-flop synchroniser with rising edge detection.
`timescale 1ns/1ps
module ssl_sync
(
   input  wire clk_sys_in,
   input  wire reset_n_in,
   input  wire async_in,
   output reg  level_out,
   output wire rise_out
);
   reg meta;
   reg prev;

   always @(posedge clk_sys_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         meta      <= 1'b0;
         level_out <= 1'b0;
         prev      <= 1'b0;
      end
      else
      begin
         meta      <= async_in;
         level_out <= meta;
         prev      <= level_out;
      end
   end

   assign rise_out = level_out & ~prev;
endmodule

/* File: design/ssl_buf.v */
// Two-entry valid/ready buffer for the latched words.
`timescale 1ns/1ps
module ssl_buf
#(
   parameter WIDTH = 8,
   parameter DEPTH = 2
)
(
   input  wire             clk_sys_in,
   input  wire             reset_n_in,
   input  wire             flush_in,
   input  wire [WIDTH-1:0] in_data_in,
   input  wire             in_valid_in,
   output wire             in_ready_out,
   output wire [WIDTH-1:0] out_data_out,
   output wire             out_valid_out,
   input  wire             out_ready_in
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [1:0]       count;
   reg             rd_ptr;
   reg             wr_ptr;
   wire            do_wr;
   wire            do_rd;

   assign in_ready_out  = (count != DEPTH);
   assign out_valid_out = (count != 2'h0);
   assign out_data_out  = mem[rd_ptr];
   assign do_wr = in_valid_in & in_ready_out;
   assign do_rd = out_valid_out & out_ready_in;

   always @(posedge clk_sys_in)
   begin
      if (do_wr)
         mem[wr_ptr] <= in_data_in;
   end

   always @(posedge clk_sys_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         count  <= 2'h0;
         rd_ptr <= 1'b0;
         wr_ptr <= 1'b0;
      end
      else if (flush_in)
      begin
         count  <= 2'h0;
         rd_ptr <= 1'b0;
         wr_ptr <= 1'b0;
      end
      else
      begin
         if (do_wr)
            wr_ptr <= ~wr_ptr;
         if (do_rd)
            rd_ptr <= ~rd_ptr;
         if (do_wr && !do_rd)
            count <= count + 2'h1;
         else if (do_rd && !do_wr)
            count <= count - 2'h1;
      end
   end
endmodule

/* File: design/ssl_top.v */
// Serial shift register with storage latch and open-drain outputs.
`timescale 1ns/1ps
`include "ssl_regs.vh"
module ssl_top
#(
   parameter WIDTH = `SSL_WIDTH
)
(
   input  wire             clk_sys_in,
   input  wire             reset_n_in,
   input  wire             serial_in,
   input  wire             shift_clk_in,
   input  wire             latch_clk_in,
   input  wire             clear_n_in,
   input  wire             out_enable_n_in,
   output reg              cascade_out,
   output reg  [WIDTH-1:0] drain_in_out,
   output reg  [WIDTH-1:0] drain_oe_out,
   output reg  [WIDTH-1:0] word_data_out,
   output reg              word_valid_out,
   input  wire             word_ready_in
);
   reg  [WIDTH-1:0] shift_reg;
   reg  [WIDTH-1:0] store_reg;
   reg              data_m;
   reg              data_s;
   reg              oe_m;
   reg              oe_s;
   reg              clr_m;
   reg              clr_s;
   wire             shift_rise;
   wire             latch_rise;
   wire             buf_in_ready;
   wire [WIDTH-1:0] buf_data;
   wire             buf_valid;
   wire             buf_pop;
   wire             clear_now;

   ssl_sync u_shift_sync
   (
      .clk_sys_in (clk_sys_in),
      .reset_n_in (reset_n_in),
      .async_in   (shift_clk_in),
      .level_out  (),
      .rise_out   (shift_rise)
   );

   ssl_sync u_latch_sync
   (
      .clk_sys_in (clk_sys_in),
      .reset_n_in (reset_n_in),
      .async_in   (latch_clk_in),
      .level_out  (),
      .rise_out   (latch_rise)
   );

   // Data and controls pass two flip-flops, matching the clock path delay.
   always @(posedge clk_sys_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         data_m <= 1'b0;
         data_s <= 1'b0;
         oe_m   <= 1'b1;
         oe_s   <= 1'b1;
         clr_m  <= 1'b0;
         clr_s  <= 1'b0;
      end
      else
      begin
         data_m <= serial_in;
         data_s <= data_m;
         oe_m   <= out_enable_n_in;
         oe_s   <= oe_m;
         clr_m  <= clear_n_in;
         clr_s  <= clr_m;
      end
   end

   // Clear acts on the sampled level alone, with no shift or latch edge.
   assign clear_now = ~clr_s;

   // Shift and storage registers; the enable takes no part here.
   always @(posedge clk_sys_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         shift_reg <= {WIDTH{1'b0}};
         store_reg <= {WIDTH{1'b0}};
      end
      else if (clear_now)
      begin
         shift_reg <= {WIDTH{1'b0}};
         store_reg <= {WIDTH{1'b0}};
      end
      else
      begin
         if (shift_rise)
            shift_reg <= {shift_reg[WIDTH-2:0], data_s};
         // Old shift value is copied, so tied clocks lag one pulse.
         if (latch_rise)
            store_reg <= shift_reg;
      end
   end

   // Cascade output follows the last stage, so it moves only on shifts and clears.
   always @(posedge clk_sys_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         cascade_out <= 1'b0;
      else
         cascade_out <= shift_reg[WIDTH-1];
   end

   // Open-drain drive: pull low where a one is stored and outputs are on.
   always @(posedge clk_sys_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         drain_in_out <= {WIDTH{1'b0}};
         drain_oe_out <= {WIDTH{1'b0}};
      end
      else
      begin
         drain_in_out <= {WIDTH{1'b0}};
         if (oe_s)
            drain_oe_out <= {WIDTH{1'b0}};
         else
            drain_oe_out <= store_reg;
      end
   end

   // Each latched word is queued for a monitoring consumer while the buffer has room.
   ssl_buf
   #(
      .WIDTH (WIDTH),
      .DEPTH (`SSL_BUF_DEPTH)
   )
   u_buf
   (
      .clk_sys_in    (clk_sys_in),
      .reset_n_in    (reset_n_in),
      .flush_in      (clear_now),
      .in_data_in    (shift_reg),
      .in_valid_in   (latch_rise & ~clear_now),
      .in_ready_out  (buf_in_ready),
      .out_data_out  (buf_data),
      .out_valid_out (buf_valid),
      .out_ready_in  (buf_pop)
   );

   // Output register stage; takes a word when empty or being taken.
   assign buf_pop = buf_valid & (~word_valid_out | word_ready_in);

   always @(posedge clk_sys_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         word_valid_out <= 1'b0;
         word_data_out  <= {WIDTH{1'b0}};
      end
      else if (clear_now)
         word_valid_out <= 1'b0;
      else if (buf_pop)
      begin
         word_valid_out <= 1'b1;
         word_data_out  <= buf_data;
      end
      else if (word_ready_in)
         word_valid_out <= 1'b0;
   end

   // A full buffer drops a latch word only for the monitor, never storage.
   wire unused_ready = buf_in_ready;
endmodule

/* File: testbench/ssl_checker.sv */
// Port assertions for the shift latch driver.
`timescale 1ns/1ps
module ssl_checker
#(
   parameter WIDTH = 8
)
(
   input wire             clk_sys_in,
   input wire             reset_n_in,
   input wire             serial_in,
   input wire             shift_clk_in,
   input wire             latch_clk_in,
   input wire             clear_n_in,
   input wire             out_enable_n_in,
   input wire             cascade_out,
   input wire [WIDTH-1:0] drain_in_out,
   input wire [WIDTH-1:0] drain_oe_out,
   input wire [WIDTH-1:0] word_data_out,
   input wire             word_valid_out,
   input wire             word_ready_in
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!reset_n_in);
   property p_drv; drain_in_out == 0; endproperty
   a_drv: assert property (p_drv) else $error("drain level");
   property p_off; out_enable_n_in[*4] |-> drain_oe_out == 0; endproperty
   a_off: assert property (p_off) else $error("drain on");
   property p_on; drain_oe_out != 0 |->
      !$past(out_enable_n_in, 3) || !$past(out_enable_n_in, 4); endproperty
   a_on: assert property (p_on) else $error("drain on late");
   property p_clr; !clear_n_in[*5] |->
      drain_oe_out == 0 && !cascade_out && !word_valid_out; endproperty
   a_clr: assert property (p_clr) else $error("not cleared");
   property p_cas;
      (!shift_clk_in && clear_n_in)[*8] |=> $stable(cascade_out); endproperty
   a_cas: assert property (p_cas) else $error("cascade moved");
   property p_lat; (!latch_clk_in && clear_n_in && !out_enable_n_in)[*8]
      |=> $stable(drain_oe_out); endproperty
   a_lat: assert property (p_lat) else $error("drain moved");
   property p_hold; clear_n_in[*5] ##0 (word_valid_out && !word_ready_in)
      |=> word_valid_out && $stable(word_data_out); endproperty
   a_hold: assert property (p_hold) else $error("word lost");
   property p_word; word_ready_in[*3] ##0 ($rose(latch_clk_in) &&
      clear_n_in) |-> ##[3:6] word_valid_out; endproperty
   a_word: assert property (p_word) else $error("no word");
   c_take: cover property (word_valid_out && word_ready_in);
   c_tied: cover property ($rose(latch_clk_in) && shift_clk_in);
   c_flush: cover property (!clear_n_in && word_valid_out);
endmodule

/* File: testbench/ssl_host.sv */
// Host model that shifts words in and strobes the latch.
`timescale 1ns/1ps
module ssl_host
(
   input  wire clk_sys_in,
   output reg  serial_out = 1'b0,
   output reg  shift_clk_out = 1'b0,
   output reg  latch_clk_out = 1'b0
);
   // Sends the top bit first; t pulses the latch with every shift edge.
   task send(input [7:0] w, input t);
      integer i;
      for (i = 7; i >= 0; i = i - 1)
      begin
         serial_out <= w[i];
         repeat (8) @(posedge clk_sys_in);
         shift_clk_out <= 1'b1;
         latch_clk_out <= t;
         repeat (8) @(posedge clk_sys_in);
         shift_clk_out <= 1'b0;
         latch_clk_out <= 1'b0;
      end
      repeat (8) @(posedge clk_sys_in);
      latch_clk_out <= ~t;
      repeat (8) @(posedge clk_sys_in);
      latch_clk_out <= 1'b0;
      serial_out <= ~w[0];
   endtask
endmodule

/* File: testbench/ssl_top_tb.sv */
// Self-checking bench for the shift latch driver.
`timescale 1ns/1ps
module ssl_top_tb;
   logic       clk_sys_in = 0;
   logic       reset_n_in = 0;
   logic       clear_n_in = 1;
   logic       out_enable_n_in = 0;
   logic       word_ready_in = 0;
   wire        serial_in, shift_clk_in, latch_clk_in;
   wire        cascade_out, word_valid_out;
   wire  [7:0] drain_in_out, drain_oe_out, word_data_out;
   logic [7:0] sh = 0, st = 0;
   logic [7:0] q[$];
   int         miscompares = 0, num_checks = 0, cyc = 0;
   bit         stall = 0;
   ssl_host host_u (.clk_sys_in, .serial_out(serial_in),
      .shift_clk_out(shift_clk_in), .latch_clk_out(latch_clk_in));
   ssl_top dut_u (.clk_sys_in, .reset_n_in, .serial_in, .shift_clk_in,
      .latch_clk_in, .clear_n_in, .out_enable_n_in, .cascade_out,
      .drain_in_out, .drain_oe_out, .word_data_out, .word_valid_out,
      .word_ready_in);
   initial
   begin
      forever #5 clk_sys_in = ~clk_sys_in;
   end
   task results;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input logic [7:0] g, e);
      num_checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("ERROR %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // A stall holds three words, two buffered and one presented; more drop.
   task push(input logic [7:0] v);
      st = v;
      if (!stall || q.size() < 3)
         q.push_back(v);
   endtask
   task frame(input logic [7:0] w, input logic t);
      for (int i = 7; i >= 0; i--)
      begin
         if (t)
            push(sh);
         sh = {sh[6:0], w[i]};
      end
      if (!t)
         push(sh);
      host_u.send(w, t);
      repeat (20) @(posedge clk_sys_in);
      chk(8'(cascade_out), sh[7]);
      chk(drain_oe_out, out_enable_n_in ? 8'h00 : st);
      chk(drain_in_out, 8'h00);
   endtask
   always @(posedge clk_sys_in)
   begin
      word_ready_in <= stall ? 1'b0 : 1'($urandom % 2);
      cyc <= cyc + 1;
      if (word_valid_out && word_ready_in)
         chk(word_data_out, q.size() ? q.pop_front() : 8'hXX);
      if (cyc == 12000)
      begin
         miscompares++;
         results;
      end
   end
   initial
   begin
      void'($urandom(32'hA353));
      repeat (8) @(posedge clk_sys_in);
      reset_n_in <= 1'b1;
      repeat (8) @(posedge clk_sys_in);
      repeat (20)
      begin
         out_enable_n_in <= 1'($urandom % 2);
         frame(8'($urandom), 1'($urandom % 2));
      end
      $display("test random frames done");
      stall = 1;
      out_enable_n_in <= 1'b0;
      repeat (4)
         frame(8'($urandom), 1'b0);
      chk(8'(word_valid_out), 8'h01);
      stall = 0;
      repeat (40) @(posedge clk_sys_in);
      chk(8'(q.size()), 8'h00);
      $display("test stall done");
      stall = 1;
      frame(8'hA5, 1'b0);
      clear_n_in <= 1'b0;
      q.delete();
      sh = 0;
      st = 0;
      repeat (10) @(posedge clk_sys_in);
      chk(drain_oe_out | 8'({word_valid_out, cascade_out}), 8'h00);
      clear_n_in <= 1'b1;
      stall = 0;
      frame(8'h3C, 1'b1);
      chk(8'(q.size()), 8'h00);
      $display("test clear done");
      results;
   end
endmodule
bind ssl_top ssl_checker #(.WIDTH(WIDTH)) chk_u (.clk_sys_in, .reset_n_in,
   .serial_in, .shift_clk_in, .latch_clk_in, .clear_n_in, .out_enable_n_in,
   .cascade_out, .drain_in_out, .drain_oe_out, .word_data_out,
   .word_valid_out, .word_ready_in);
